// File: hdl/phy_mii_nibble_interface.sv
// phy side of the media independent nibble interface: clocks, tx encode, rx decode
// assumes mac pins are asynchronous to core_clk, and rx code groups arrive on line_clk
// What this block does
// RULE_01: receive bus bit 0 is nibble lsb, bit 3 is msb.
// RULE_02: while valid is high each nibble is presented per receive clock rising edge.
// RULE_03: valid rises only after the J then K delimiter pair is seen; slow mode takes valid straight from receive code bit 4.
// RULE_04: valid drops on T then R delimiter or on a signal error; the code drops valid at T and never checks for R.
// RULE_05: fast mode flags receive error for errors inside a valid frame.
// RULE_06: fast mode flags receive error on a false carrier.
// RULE_07: slow mode never flags receive error.
// RULE_08: receive error and valid change only with the receive clock; the float request clears receive error on any line clock edge.
// RULE_09: receive error is gated off by the receive float request.
// RULE_10: mac raises float request when floating; then this phy releases the bus.
// RULE_11: transmit clock runs at 2.5 MHz slow and 25 MHz fast.
// RULE_12: mac times all transmit signals from our transmit clock.
// RULE_13: transmit bus bit 0 is nibble lsb, bit 3 is msb.
// RULE_14: transmit nibble sampled on each transmit clock rise while enable is high.
// RULE_15: enable starts sampling and nibbles go out to the line.
// RULE_16: enable low ends the transmission on the line.
// RULE_17: fast mode samples transmit error on each transmit clock rise.
// RULE_18: slow mode ignores transmit error.
// RULE_19: transmit error replaces the nibble with an invalid code group.
// RULE_20: with test bit set errored nibbles use the separate invalid table.
// RULE_21: receive clock runs at 2.5 MHz slow and 25 MHz fast.
// RULE_22: the substituted halt group is 00100 in place of the encoding.
module phy_mii_nibble_interface (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       speed_100,
  input  wire logic       invalid_code_test,
  input  wire logic [3:0] mii_txd,
  input  wire logic       mii_tx_en,
  input  wire logic       mii_tx_er,
  output logic            mii_tx_clk,
  output logic      [4:0] line_tx_code,
  output logic            line_tx_valid,
  input  wire logic       line_clk,
  input  wire logic [4:0] line_rx_code,
  input  wire logic       receive_float_request,
  output logic            mii_rx_clk,
  output logic      [3:0] mii_rxd,
  output logic            mii_rx_dv,
  output logic            mii_rx_er,
  output logic            mii_rx_drive_n
);

  // ------------------------------------------------------------
  // core domain: pin capture
  // ------------------------------------------------------------
  mii_pkg::tx_pins_type tx_raw;
  mii_pkg::tx_pins_type tx_s;
  logic [7:0]           core_sync;
  logic                 speed_s;
  logic                 test_s;

  assign tx_raw = '{nib: mii_txd, en: mii_tx_en, er: mii_tx_er};

  sync2 #(.WIDTH(8)) core_pin_sync (
    .clk (core_clk),
    .d   ({speed_100, invalid_code_test, tx_raw}),
    .q   (core_sync)
  );

  assign {speed_s, test_s, tx_s} = core_sync;

  // ------------------------------------------------------------
  // core domain: transmit clock divider
  // ------------------------------------------------------------
  logic [5:0] tx_cnt_q;
  logic [5:0] tx_cnt_d;
  logic       tx_clk_q;
  logic       tx_clk_d;
  wire  [5:0] tx_div  = speed_s ? mii_pkg::TX_DIV_FAST : mii_pkg::TX_DIV_SLOW;
  // >= rather than == so a speed change mid-count cannot strand the counter
  wire        tx_tick = tx_cnt_q >= tx_div - 6'h01;

  assign tx_cnt_d = tx_tick ? 6'h00 : 6'(tx_cnt_q + 6'h01);
  assign tx_clk_d = tx_cnt_d < (tx_div >> 1); // RULE_11

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_cnt_q <= '1; // wraps on the first edge, so no runt clock pulse after reset
      tx_clk_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      tx_clk_q <= tx_clk_d;
    end
  end

  // ------------------------------------------------------------
  // core domain: transmit encoder
  // ------------------------------------------------------------
  // synchroniser lag means the value taken at the rising edge was on the pins before it
  mii_pkg::tx_state_type tx_state_q;
  mii_pkg::tx_state_type tx_state_d;
  logic [4:0]            tx_code_q;
  logic [4:0]            tx_code_d;
  logic                  tx_valid_q;
  logic                  tx_valid_d;

  wire       tx_err_eff = tx_s.er & speed_s;                                        // RULE_17 RULE_18
  wire [4:0] err_code   = test_s ? mii_pkg::invalid_test_code(tx_s.nib) : mii_pkg::CODE_HALT; // RULE_20 RULE_22
  wire [4:0] fast_code  = tx_err_eff ? err_code : mii_pkg::encode_nibble(tx_s.nib); // RULE_19
  wire [4:0] slow_code  = {1'b0, tx_s.nib};                                         // RULE_13

  always_comb begin
    tx_state_d = tx_state_q;
    tx_code_d  = tx_code_q;
    tx_valid_d = tx_valid_q;
    if (tx_tick) begin // RULE_14
      case (tx_state_q)
        mii_pkg::TX_IDLE: begin
          if (tx_s.en) begin // RULE_15
            tx_valid_d = 1'b1;
            if (speed_s) begin
              tx_code_d  = mii_pkg::CODE_J;
              tx_state_d = mii_pkg::TX_SEND_K;
            end else begin
              tx_code_d  = slow_code;
              tx_state_d = mii_pkg::TX_DATA;
            end
          end else begin
            tx_valid_d = 1'b0;
            tx_code_d  = speed_s ? mii_pkg::CODE_IDLE : mii_pkg::CODE_NONE;
          end
        end
        mii_pkg::TX_SEND_K: begin
          tx_code_d  = mii_pkg::CODE_K;
          tx_state_d = mii_pkg::TX_DATA;
        end
        mii_pkg::TX_DATA: begin
          if (tx_s.en) begin
            tx_code_d = speed_s ? fast_code : slow_code;
          end else if (speed_s) begin // RULE_16
            tx_code_d  = mii_pkg::CODE_T;
            tx_state_d = mii_pkg::TX_END_R;
          end else begin
            tx_valid_d = 1'b0;
            tx_code_d  = mii_pkg::CODE_NONE;
            tx_state_d = mii_pkg::TX_IDLE;
          end
        end
        mii_pkg::TX_END_R: begin
          tx_code_d  = mii_pkg::CODE_R;
          tx_state_d = mii_pkg::TX_IDLE;
        end
        default: begin
          tx_state_d = mii_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_state_q <= mii_pkg::TX_IDLE;
      tx_code_q  <= mii_pkg::CODE_NONE;
      tx_valid_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      tx_code_q  <= tx_code_d;
      tx_valid_q <= tx_valid_d;
    end
  end

  assign mii_tx_clk    = tx_clk_q; // RULE_12
  assign line_tx_code  = tx_code_q;
  assign line_tx_valid = tx_valid_q;

  // ------------------------------------------------------------
  // line domain: reset, speed and float crossing
  // ------------------------------------------------------------
  logic       line_rst;
  logic [1:0] line_sync;
  logic       speed_l;
  logic       float_l;

  sync2 #(.WIDTH(1)) line_rst_sync (
    .clk (line_clk),
    .d   (srst),
    .q   (line_rst)
  );

  sync2 #(.WIDTH(2)) line_lvl_sync (
    .clk (line_clk),
    .d   ({speed_s, receive_float_request}),
    .q   (line_sync)
  );

  assign {speed_l, float_l} = line_sync;

  // ------------------------------------------------------------
  // line domain: receive clock
  // ------------------------------------------------------------
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_cnt_d;
  logic       rx_clk_q;
  wire  [3:0] rx_half = speed_l ? mii_pkg::RX_HALF_FAST : mii_pkg::RX_HALF_SLOW;
  wire        rx_edge = rx_cnt_q >= rx_half - 4'h1;
  wire        rx_take = rx_edge & ~rx_clk_q;

  assign rx_cnt_d = rx_edge ? 4'h0 : 4'(rx_cnt_q + 4'h1);

  always_ff @(posedge line_clk) begin
    if (line_rst) begin
      rx_cnt_q <= 4'h0;
      rx_clk_q <= 1'b0;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      rx_clk_q <= rx_edge ? ~rx_clk_q : rx_clk_q; // RULE_21
    end
  end

  // ------------------------------------------------------------
  // line domain: receive decoder
  // ------------------------------------------------------------
  mii_pkg::rx_state_type rx_state_q;
  mii_pkg::rx_state_type rx_state_d;
  mii_pkg::rx_bus_type   rx_q;
  mii_pkg::rx_bus_type   rx_d;
  logic                  rx_drive_n_q;

  wire [4:0] dec_w   = mii_pkg::decode_code(line_rx_code);
  wire       dec_ok  = dec_w[4];
  wire       is_idle = line_rx_code == mii_pkg::CODE_IDLE;

  always_comb begin
    rx_state_d = rx_state_q;
    rx_d       = rx_q;
    if (rx_take) begin // RULE_02 RULE_08
      if (!speed_l) begin
        rx_d       = '{nib: line_rx_code[3:0], dv: line_rx_code[4], er: 1'b0}; // RULE_07
        rx_state_d = mii_pkg::RX_IDLE;
      end else begin
        case (rx_state_q)
          mii_pkg::RX_IDLE: begin
            rx_d = '{nib: mii_pkg::NIB_ZERO, dv: 1'b0, er: 1'b0};
            if (line_rx_code == mii_pkg::CODE_J) begin
              rx_state_d = mii_pkg::RX_GOT_J;
            end else if (!is_idle) begin // RULE_06
              rx_d = '{nib: mii_pkg::NIB_FALSE_CARRIER, dv: 1'b0, er: 1'b1};
            end
          end
          mii_pkg::RX_GOT_J: begin
            if (line_rx_code == mii_pkg::CODE_K) begin // RULE_03
              rx_d       = '{nib: mii_pkg::NIB_PREAMBLE, dv: 1'b1, er: 1'b0};
              rx_state_d = mii_pkg::RX_DATA;
            end else begin
              rx_d       = '{nib: mii_pkg::NIB_FALSE_CARRIER, dv: 1'b0, er: 1'b1};
              rx_state_d = mii_pkg::RX_IDLE;
            end
          end
          mii_pkg::RX_DATA: begin
            if (dec_ok) begin
              rx_d = '{nib: dec_w[3:0], dv: 1'b1, er: 1'b0}; // RULE_01
            end else if (line_rx_code == mii_pkg::CODE_T) begin // RULE_04
              rx_d       = '{nib: mii_pkg::NIB_ZERO, dv: 1'b0, er: 1'b0};
              rx_state_d = mii_pkg::RX_GOT_T;
            end else begin
              // errored nibble is flagged while still valid, then the frame is cut
              rx_d       = '{nib: mii_pkg::NIB_ZERO, dv: 1'b1, er: 1'b1}; // RULE_05
              rx_state_d = mii_pkg::RX_IDLE; // RULE_04
            end
          end
          default: begin
            rx_d       = '{nib: mii_pkg::NIB_ZERO, dv: 1'b0, er: 1'b0};
            rx_state_d = mii_pkg::RX_IDLE;
          end
        endcase
      end
    end
    rx_d.er = rx_d.er & ~float_l; // RULE_09
  end

  always_ff @(posedge line_clk) begin
    if (line_rst) begin
      rx_state_q   <= mii_pkg::RX_IDLE;
      rx_q         <= '{nib: mii_pkg::NIB_ZERO, dv: 1'b0, er: 1'b0};
      rx_drive_n_q <= 1'b1;
    end else begin
      rx_state_q   <= rx_state_d;
      rx_q         <= rx_d;
      rx_drive_n_q <= float_l; // RULE_10
    end
  end

  assign mii_rx_clk     = rx_clk_q;
  assign mii_rxd        = rx_q.nib;
  assign mii_rx_dv      = rx_q.dv;
  assign mii_rx_er      = rx_q.er;
  assign mii_rx_drive_n = rx_drive_n_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_tx_clk_fast: assert property (@(posedge core_clk) disable iff (srst) // RULE_11
    ($rose(tx_clk_q) && speed_s && $stable(speed_s)) ##1 speed_s [*5] |-> $rose(tx_clk_q))
    else $error("tx clock not at fast rate");

  chk_tx_hold_between: assert property (@(posedge core_clk) disable iff (srst) // RULE_14
    !tx_tick |=> $stable(tx_code_q) && $stable(tx_valid_q))
    else $error("tx code moved off a tx clock edge");

  chk_tx_start_j: assert property (@(posedge core_clk) disable iff (srst) // RULE_15
    (tx_tick && tx_state_q == mii_pkg::TX_IDLE && tx_s.en && speed_s)
      |=> tx_code_q == mii_pkg::CODE_J && tx_valid_q)
    else $error("fast frame did not open with J");

  chk_tx_end_slow: assert property (@(posedge core_clk) disable iff (srst) // RULE_16
    (tx_tick && tx_state_q == mii_pkg::TX_DATA && !tx_s.en && !speed_s) |=> !tx_valid_q)
    else $error("slow frame not ended after enable fell");

  chk_tx_end_fast: assert property (@(posedge core_clk) disable iff (srst) // RULE_16
    (tx_tick && tx_state_q == mii_pkg::TX_DATA && !tx_s.en && speed_s)
      |=> tx_code_q == mii_pkg::CODE_T ##[1:50] tx_code_q == mii_pkg::CODE_R)
    else $error("fast frame not ended with T R");

  chk_tx_halt_sub: assert property (@(posedge core_clk) disable iff (srst) // RULE_19 RULE_22
    (tx_tick && tx_state_q == mii_pkg::TX_DATA && tx_s.en && tx_s.er && speed_s && !test_s)
      |=> tx_code_q == mii_pkg::CODE_HALT)
    else $error("tx error did not send halt");

  chk_tx_test_table: assert property (@(posedge core_clk) disable iff (srst) // RULE_20
    (tx_tick && tx_state_q == mii_pkg::TX_DATA && tx_s.en && tx_s.er && speed_s && test_s)
      |=> tx_code_q == mii_pkg::invalid_test_code($past(tx_s.nib)))
    else $error("test table code not sent");

  chk_tx_slow_no_err: assert property (@(posedge core_clk) disable iff (srst) // RULE_18
    (tx_tick && tx_state_q == mii_pkg::TX_DATA && tx_s.en && !speed_s)
      |=> tx_code_q == {1'b0, $past(tx_s.nib)})
    else $error("slow nibble altered");

  chk_rx_float_er: assert property (@(posedge line_clk) disable iff (line_rst) // RULE_09
    float_l |=> !rx_q.er)
    else $error("rx error driven while float requested");

  chk_rx_slow_no_er: assert property (@(posedge line_clk) disable iff (line_rst) // RULE_07
    (rx_take && !speed_l) |=> !rx_q.er)
    else $error("rx error raised in slow mode");

  chk_rx_dv_after_jk: assert property (@(posedge line_clk) disable iff (line_rst) // RULE_03
    ($rose(rx_q.dv) && speed_l) |-> $past(rx_state_q) == mii_pkg::RX_GOT_J)
    else $error("rx valid rose without J K");

  chk_rx_sync_edge: assert property (@(posedge line_clk) disable iff (line_rst) // RULE_08
    !rx_take |=> $stable(rx_q.dv) && $stable(rx_q.nib))
    else $error("rx outputs moved off a rx clock edge");

  chk_rx_tr_end: assert property (@(posedge line_clk) disable iff (line_rst) // RULE_04
    (rx_take && speed_l && rx_state_q == mii_pkg::RX_DATA && line_rx_code == mii_pkg::CODE_T)
      |=> !rx_q.dv)
    else $error("rx valid held past T");

  chk_rx_false_car: assert property (@(posedge line_clk) disable iff (line_rst) // RULE_06
    (rx_take && speed_l && rx_state_q == mii_pkg::RX_IDLE && !is_idle
      && line_rx_code != mii_pkg::CODE_J && !float_l) |=> rx_q.er && !rx_q.dv)
    else $error("false carrier not flagged");

  cov_tx_frame: cover property (@(posedge core_clk) disable iff (srst)
    tx_state_q == mii_pkg::TX_END_R ##1 tx_state_q == mii_pkg::TX_IDLE);

  cov_tx_halt: cover property (@(posedge core_clk) disable iff (srst)
    tx_valid_q && tx_code_q == mii_pkg::CODE_HALT);

  cov_rx_frame: cover property (@(posedge line_clk) disable iff (line_rst)
    rx_state_q == mii_pkg::RX_GOT_T);

  cov_rx_false: cover property (@(posedge line_clk) disable iff (line_rst)
    rx_q.er && !rx_q.dv);

endmodule : phy_mii_nibble_interface

// File: hdl/mii_pkg.sv
// constants, codes and carrier types for the phy side of the nibble interface
// assumes a 125 MHz core clock and a 50 MHz recovered line clock
package mii_pkg;

  // ------------------------------------------------------------
  // clock rates and dividers
  // ------------------------------------------------------------
  localparam int CORE_CLK_KHZ  = 125000;
  localparam int LINE_CLK_KHZ  = 50000;
  localparam int FAST_LINK_KHZ = 25000;
  localparam int SLOW_LINK_KHZ = 2500;

  localparam logic [5:0] TX_DIV_FAST  = 6'(CORE_CLK_KHZ / FAST_LINK_KHZ);
  localparam logic [5:0] TX_DIV_SLOW  = 6'(CORE_CLK_KHZ / SLOW_LINK_KHZ);
  localparam logic [3:0] RX_HALF_FAST = 4'(LINE_CLK_KHZ / FAST_LINK_KHZ / 2);
  localparam logic [3:0] RX_HALF_SLOW = 4'(LINE_CLK_KHZ / SLOW_LINK_KHZ / 2);

  // ------------------------------------------------------------
  // line code groups
  // ------------------------------------------------------------
  localparam logic [4:0] CODE_IDLE = 5'h1F;
  localparam logic [4:0] CODE_J    = 5'h18;
  localparam logic [4:0] CODE_K    = 5'h11;
  localparam logic [4:0] CODE_T    = 5'h0D;
  localparam logic [4:0] CODE_R    = 5'h07;
  localparam logic [4:0] CODE_HALT = 5'h04;
  localparam logic [4:0] CODE_NONE = 5'h00;

  localparam logic [3:0] NIB_FALSE_CARRIER = 4'hE;
  localparam logic [3:0] NIB_PREAMBLE      = 4'h5;
  localparam logic [3:0] NIB_ZERO          = 4'h0;

  // ------------------------------------------------------------
  // carriers and states
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] nib;
    logic       en;
    logic       er;
  } tx_pins_type;

  typedef struct packed {
    logic [3:0] nib;
    logic       dv;
    logic       er;
  } rx_bus_type;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_SEND_K = 2'b01,
    TX_DATA   = 2'b10,
    TX_END_R  = 2'b11
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_GOT_J = 2'b01,
    RX_DATA  = 2'b10,
    RX_GOT_T = 2'b11
  } rx_state_type;

  // ------------------------------------------------------------
  // code tables
  // ------------------------------------------------------------
  function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
    logic [4:0] c;
    c = CODE_NONE;
    case (nib)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction : encode_nibble

  // returns {ok, nibble}
  function automatic logic [4:0] decode_code(input logic [4:0] code);
    logic [4:0] r;
    r = {1'b0, NIB_ZERO};
    for (int i = 0; i < 16; i++) begin
      if (encode_nibble(4'(i)) == code) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : decode_code

  // test table of invalid code groups, one per nibble
  function automatic logic [4:0] invalid_test_code(input logic [3:0] nib);
    logic [4:0] c;
    c = CODE_HALT;
    case (nib)
      4'h0, 4'hA: c = 5'h00;
      4'h1, 4'hB: c = 5'h01;
      4'h2, 4'hC: c = 5'h02;
      4'h3, 4'hD: c = 5'h03;
      4'h4, 4'hE: c = 5'h05;
      4'h5, 4'hF: c = 5'h06;
      4'h6: c = 5'h08;
      4'h7: c = 5'h0C;
      4'h8: c = 5'h10;
      default: c = 5'h19;
    endcase
    return c;
  endfunction : invalid_test_code

endpackage : mii_pkg

// File: hdl/sync2.sv
// two flip-flop level synchroniser
// assumes each bit is a slow level; words passed here, such as the transmit nibble, must hold steady for several clocks
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule : sync2

// File: tb/mac_model.sv
// mac side model: transmit pins timed from the phy transmit clock, plus float request
// assumes the bench calls put once per transmit clock period and nothing else drives these pins
module mac_model (
  input  wire logic       mii_tx_clk,
  output logic      [3:0] mii_txd,
  output logic            mii_tx_en,
  output logic            mii_tx_er,
  output logic            receive_float_request
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mii_txd               = 4'h0;
    mii_tx_en             = 1'b0;
    mii_tx_er             = 1'b0;
    receive_float_request = 1'b0;
  end

  // ------------------------------------------------------------
  // transmit pins
  // ------------------------------------------------------------
  // changed just after the rise, so the phy sees a full stable period
  task automatic put(input logic [3:0] nib, input logic en, input logic er);
    @(posedge mii_tx_clk);
    mii_tx_en <= en;
    mii_tx_er <= er;
    // no stale copy between frames: idle data toggles
    mii_txd   <= en ? nib : ~mii_txd;
  endtask : put

  task automatic set_float(input logic f);
    @(posedge mii_tx_clk);
    receive_float_request <= f;
  endtask : set_float
endmodule : mac_model

// File: tb/phy_mii_nibble_interface_tb_top.sv
// bench for the phy nibble interface: behavioural tx and rx models compared at every nibble
// assumes mac_model drives the mac pins; the bench drives the line receive side itself
module phy_mii_nibble_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk, line_clk, srst, speed_100, invalid_code_test, receive_float_request;
  logic       mii_tx_en, mii_tx_er, mii_tx_clk, line_tx_valid, mii_rx_clk, mii_rx_dv, mii_rx_er;
  logic       mii_rx_drive_n, rx_have;
  logic [3:0] mii_txd, mii_rxd;
  logic [4:0] line_tx_code, line_rx_code;
  logic [6:0] rx_prev;
  int         error_cnt, n_compared, cyc, rs;
  logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [4:0] itab [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C,
                            5'h10, 5'h19, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06};

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // phase offset keeps the two domains unrelated
  initial begin
    line_clk = 1'b0;
    #3;
    forever #40 line_clk = ~line_clk;
  end

  phy_mii_nibble_interface dut (
    .core_clk(core_clk), .srst(srst), .speed_100(speed_100), .invalid_code_test(invalid_code_test),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_tx_clk(mii_tx_clk),
    .line_tx_code(line_tx_code), .line_tx_valid(line_tx_valid), .line_clk(line_clk),
    .line_rx_code(line_rx_code), .receive_float_request(receive_float_request),
    .mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
    .mii_rx_drive_n(mii_rx_drive_n));

  mac_model mac (
    .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er),
    .receive_float_request(receive_float_request));

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // generous: the whole run is a few thousand core cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic clk_period(input int exp_tx, input int exp_rx);
    time t0;
    time t1;
    @(posedge mii_tx_clk);
    t0 = $time;
    @(posedge mii_tx_clk);
    t1 = $time;
    check(8'((t1 - t0) / 8), 8'(exp_tx));
    @(posedge mii_rx_clk);
    t0 = $time;
    @(posedge mii_rx_clk);
    t1 = $time;
    check(8'((t1 - t0) / 80), 8'(exp_rx));
  endtask : clk_period

  // each code leaves one period later; check the previous item at the falling edge
  task automatic tx_frame(input int n, input int er_at);
    int         s;
    logic [5:0] exp;
    logic [5:0] prev;
    logic [3:0] nib;
    logic       en;
    logic       er;
    s = 0;
    prev = 6'h00;
    for (int i = 0; i <= n + 3; i++) begin
      nib = 4'($urandom);
      en = (i < n);
      er = (i == er_at);
      mac.put(nib, en, er);
      @(negedge mii_tx_clk);
      if (i > 0) check({2'b00, line_tx_valid, line_tx_code}, {2'b00, prev});
      if (i > 0) check({3'b000, line_tx_code}, {3'b000, prev[4:0]});
      if (!speed_100) begin
        exp = en ? {2'b10, nib} : 6'h00;
      end else if (en) begin
        exp = (s == 0) ? 6'h38 : (s == 1) ? 6'h31 :
              {1'b1, er ? (invalid_code_test ? itab[nib] : 5'h04) : enc[nib]};
        s = (s < 2) ? s + 1 : 2;
      end else begin
        exp = (s == 2) ? 6'h2D : (s == 3) ? 6'h27 : 6'h1F;
        s = (s == 2) ? 3 : 0;
      end
      prev = exp;
    end
  endtask : tx_frame

  // expected word is {released, rxd, dv, er}; rxd only counts while dv or er is up
  task automatic rx_put(input logic [4:0] c);
    logic [6:0] ex;
    logic [7:0] got;
    ex = {receive_float_request, 6'h00};
    if (!speed_100) begin
      ex[5:0] = {c[3:0], c[4], 1'b0};
    end else if (rs == 0) begin
      ex[5:0] = (c == 5'h1F || c == 5'h18) ? 6'h00 : 6'h39;
      rs = (c == 5'h18) ? 1 : 0;
    end else if (rs == 1) begin
      ex[5:0] = (c == 5'h11) ? 6'h16 : 6'h39;
      rs = (c == 5'h11) ? 2 : 0;
    end else if (rs == 2) begin
      ex[5:0] = (c == 5'h0D) ? 6'h00 : 6'h03;
      for (int k = 0; k < 16; k++) begin
        if (enc[k] == c) ex[5:0] = {4'(k), 2'b10};
      end
      rs = (c == 5'h0D) ? 3 : (ex[0] ? 0 : 2);
    end else begin
      rs = 0;
    end
    if (receive_float_request) ex[0] = 1'b0;
    if (!ex[1] && !ex[0]) ex[5:2] = 4'h0;
    @(posedge mii_rx_clk);
    line_rx_code <= c;
    @(negedge mii_rx_clk);
    got = {1'b0, mii_rx_drive_n, (mii_rx_dv | mii_rx_er) ? mii_rxd : 4'h0, mii_rx_dv, mii_rx_er};
    if (rx_have) check(got, {1'b0, rx_prev});
    if (rx_have) check({6'h00, mii_rx_drive_n, mii_rx_er}, {6'h00, rx_prev[6], rx_prev[0]});
    rx_prev = ex;
    rx_have = 1'b1;
  endtask : rx_put

  // settle after a mode or float change; the pending item is dropped
  task automatic rx_gap();
    repeat (6) @(posedge mii_rx_clk);
    rx_have = 1'b0;
  endtask : rx_gap

  initial begin
    srst = 1'b1;
    speed_100 = 1'b1;
    invalid_code_test = 1'b0;
    line_rx_code = 5'h1F;
    rx_have = 1'b0;
    rs = 0;
    void'($urandom(49));
    // line domain needs its own reset edges as well
    repeat (3) @(posedge line_clk);
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (20) @(posedge core_clk);
    clk_period(5, 2);
    tx_frame(10, 5);
    invalid_code_test <= 1'b1;
    tx_frame(8, 3);
    for (int f = 0; f < 3; f++) begin
      rx_put(5'h1F);
      rx_put(5'h18);
      rx_put(5'h11);
      repeat (5) rx_put(enc[4'($urandom)]);
      if (f == 1) begin
        rx_put(5'h00);
      end else begin
        rx_put(5'h0D);
        rx_put(5'h07);
      end
      rx_put(5'h1F);
      rx_put(5'h0A);
      rx_put(5'h1F);
      if (f == 1) mac.set_float(1'b1);
      if (f == 1) rx_gap();
    end
    mac.set_float(1'b0);
    rx_gap();
    speed_100 <= 1'b0;
    repeat (600) @(posedge core_clk);
    rx_gap();
    clk_period(50, 20);
    tx_frame(6, 2);
    repeat (8) rx_put({1'($urandom), 4'($urandom)});
    rx_put(5'h0F);
    end_of_test();
  end
endmodule : phy_mii_nibble_interface_tb_top
